/* File: pkg/odr_pkg.sv */
package odr_pkg;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_CONFIG = 8'h11;
  localparam logic [7:0] ADDR_COUNT = 8'h12;
  localparam int STAT_CHANGE_BIT = 7;
  localparam int STAT_LOCKOUT_BIT = 6;
  localparam int STAT_CODE_LSB = 1;
  localparam int STAT_BACK_FRONT_BIT = 0;
  localparam int CFG_MODE_BIT = 7;
  localparam int CFG_ENABLE_BIT = 6;
  localparam logic CFG_MODE_RESET = 1'b1;
  localparam logic CFG_ENABLE_RESET = 1'b0;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [1:0] CODE_RESET = 2'h0;
  localparam logic [1:0] CODE_PORTRAIT_UP = 2'h0;
  localparam logic [1:0] CODE_PORTRAIT_DOWN = 2'h1;
  localparam logic [1:0] CODE_LANDSCAPE_RIGHT = 2'h2;
  localparam logic [1:0] CODE_LANDSCAPE_LEFT = 2'h3;
  // Output sample rate codes, fastest first.
  localparam logic [2:0] ODR_800 = 3'h0;
  localparam logic [2:0] ODR_400 = 3'h1;
  localparam logic [2:0] ODR_200 = 3'h2;
  localparam logic [2:0] ODR_100 = 3'h3;
  localparam logic [2:0] ODR_50 = 3'h4;
  localparam logic [2:0] ODR_12P5 = 3'h5;
  // Oversampling mode codes.
  localparam logic [1:0] OS_NORMAL = 2'h0;
  localparam logic [1:0] OS_LOW_NOISE_LOW_POWER = 2'h1;
  localparam logic [1:0] OS_HIGH_RESOLUTION = 2'h2;
  localparam logic [1:0] OS_LOW_POWER = 2'h3;
  // Smallest debounce step and the clock rate it is counted at.
  localparam int BASE_STEP_NS = 1250000;
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int BASE_STEP_CYCLES = BASE_STEP_NS / CLOCK_PERIOD_NS;
  // Step multiples of the base step: 1.25, 2.5, 5, 10, 20, 80 and 160 ms.
  localparam logic [7:0] MULT_1 = 8'h01;
  localparam logic [7:0] MULT_2 = 8'h02;
  localparam logic [7:0] MULT_4 = 8'h04;
  localparam logic [7:0] MULT_8 = 8'h08;
  localparam logic [7:0] MULT_16 = 8'h10;
  localparam logic [7:0] MULT_64 = 8'h40;
  localparam logic [7:0] MULT_128 = 8'h80;
endpackage

/* File: rtl/odr_step_timer.sv */
`timescale 1ns/10ps
module odr_step_timer #(
  parameter int BASE_CYCLES = odr_pkg::BASE_STEP_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic [2:0] i_output_sample_rate,
  input wire logic [1:0] i_oversampling_mode,
  output logic o_step
);
  logic [31:0] base_cnt_q;
  logic [7:0] mult_cnt_q;
  logic [7:0] mult;
  logic base_tick;
  logic high_res;

  assign high_res = i_oversampling_mode == odr_pkg::OS_HIGH_RESOLUTION;
  assign base_tick = base_cnt_q == 32'(BASE_CYCLES - 1);

  // Step equals one sample period, shortened in high resolution mode and
  // capped per oversampling mode at the slowest rates.
  always_comb
  begin
    if (i_output_sample_rate == odr_pkg::ODR_800)
      mult = odr_pkg::MULT_1;
    else if (i_output_sample_rate == odr_pkg::ODR_400 || high_res)
      mult = odr_pkg::MULT_2;
    else if (i_output_sample_rate == odr_pkg::ODR_200)
      mult = odr_pkg::MULT_4;
    else if (i_output_sample_rate == odr_pkg::ODR_100)
      mult = odr_pkg::MULT_8;
    else if (i_output_sample_rate == odr_pkg::ODR_50
             || i_oversampling_mode == odr_pkg::OS_NORMAL)
      mult = odr_pkg::MULT_16;
    else if (i_oversampling_mode == odr_pkg::OS_LOW_NOISE_LOW_POWER
             || i_output_sample_rate == odr_pkg::ODR_12P5)
      mult = odr_pkg::MULT_64;
    else
      mult = odr_pkg::MULT_128;
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      base_cnt_q <= 32'h0;
    else if (!i_run || base_tick)
      base_cnt_q <= 32'h0;
    else
      base_cnt_q <= base_cnt_q + 32'h1;
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      mult_cnt_q <= 8'h00;
    else if (!i_run)
      mult_cnt_q <= 8'h00;
    else if (base_tick)
      mult_cnt_q <= (mult_cnt_q + 8'h01 >= mult) ? 8'h00
                                                 : mult_cnt_q + 8'h01;
  end

  assign o_step = i_run && base_tick && (mult_cnt_q + 8'h01 >= mult);
endmodule

/* File: rtl/odr_orientation_regs.sv */
`timescale 1ns/10ps
// Function
// - Set change flag on first detection after standby or any result change.
// - Reading the status register clears the change flag.
// - Reading the status register clears the pending orientation interrupt.
// - Lockout bit is 1 when z-tilt trip angle exceeded, else 0.
// - Orientation code: 00 up, 01 down, 10 right, 11 left.
// - Back/front bit: 0 front, 1 back.
// - After reset back/front 0, orientation 00, lockout 0.
// - Freeze reported orientation while any axis exceeds 1.25 g.
// - Results keep updating while the change flag is set.
// - Debounce mode 0 decrements counter, 1 (default) clears it.
// - Detection runs only when enable bit is 1; enable resets to 0.
// - Eight-bit debounce count resets to zero; latency is count steps, at least one step.
// - Wake/sleep transitions in either direction reset the debounce counter.
// - Step 1.25 ms at 800 Hz, 2.5 ms at 400 Hz or high-res, else one sample period, capped at the slowest rates.
// - Interrupt source set while flag set and interrupt enabled; read clears.
module odr_orientation_regs #(
  parameter int BASE_CYCLES = odr_pkg::BASE_STEP_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  input wire logic i_active,
  input wire logic i_sleep,
  input wire logic [2:0] i_output_sample_rate,
  input wire logic [1:0] i_oversampling_mode,
  input wire logic i_orient_irq_enable,
  input wire logic i_over_range,
  input wire logic [1:0] i_raw_orient_code,
  input wire logic i_raw_back_front,
  input wire logic i_raw_tilt_lockout,
  output logic o_orient_change_flag,
  output logic o_orient_irq_source
);
  logic debounce_mode_q;
  logic orient_detect_enable_q;
  logic [7:0] debounce_count_value_q;
  logic [1:0] orient_code_q;
  logic back_front_flag_q;
  logic tilt_lockout_q;
  logic orient_change_flag_q;
  logic first_pending_q;
  logic sleep_q;
  logic [7:0] db_cnt_q;
  logic run;
  logic step;
  logic differs;
  logic reached;
  logic accept;
  logic status_read;
  logic wr_cfg;
  logic wr_cnt;

  assign run = i_active && orient_detect_enable_q;
  assign status_read = i_reg_rd && i_reg_addr == odr_pkg::ADDR_STATUS;
  assign wr_cfg = i_reg_wr && i_reg_addr == odr_pkg::ADDR_CONFIG;
  assign wr_cnt = i_reg_wr && i_reg_addr == odr_pkg::ADDR_COUNT;
  assign differs = i_raw_orient_code != orient_code_q
                   || i_raw_back_front != back_front_flag_q
                   || i_raw_tilt_lockout != tilt_lockout_q;
  assign reached = db_cnt_q + 8'h01 >= debounce_count_value_q;
  // Over-range steps are ignored so the last position stays locked.
  assign accept = step && !i_over_range
                  && (first_pending_q || (differs && reached));

  odr_step_timer #(
    .BASE_CYCLES(BASE_CYCLES)
  ) u_step (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_run(run),
    .i_output_sample_rate(i_output_sample_rate),
    .i_oversampling_mode(i_oversampling_mode),
    .o_step(step)
  );

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      debounce_mode_q <= odr_pkg::CFG_MODE_RESET;
      orient_detect_enable_q <= odr_pkg::CFG_ENABLE_RESET;
    end
    else if (wr_cfg)
    begin
      debounce_mode_q <= i_reg_wdata[odr_pkg::CFG_MODE_BIT];
      orient_detect_enable_q <= i_reg_wdata[odr_pkg::CFG_ENABLE_BIT];
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      debounce_count_value_q <= odr_pkg::COUNT_RESET;
    else if (wr_cnt)
      debounce_count_value_q <= i_reg_wdata;
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      sleep_q <= 1'b0;
    else
      sleep_q <= i_sleep;
  end

  // Counter advances one per step while a new result persists.
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      db_cnt_q <= 8'h00;
    else if (!run || sleep_q != i_sleep || accept)
      db_cnt_q <= 8'h00;
    else if (step && !i_over_range)
    begin
      if (differs)
        db_cnt_q <= (db_cnt_q == 8'hFF) ? db_cnt_q : db_cnt_q + 8'h01;
      else if (debounce_mode_q)
        db_cnt_q <= 8'h00;
      else if (db_cnt_q != 8'h00)
        db_cnt_q <= db_cnt_q - 8'h01;
    end
  end

  // Results update regardless of the change flag.
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      orient_code_q <= odr_pkg::CODE_RESET;
      back_front_flag_q <= 1'b0;
      tilt_lockout_q <= 1'b0;
    end
    else if (accept)
    begin
      orient_code_q <= i_raw_orient_code;
      back_front_flag_q <= i_raw_back_front;
      tilt_lockout_q <= i_raw_tilt_lockout;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      first_pending_q <= 1'b1;
    else if (!i_active)
      first_pending_q <= 1'b1;
    else if (accept)
      first_pending_q <= 1'b0;
  end

  // A new result in the cycle of a status read keeps the flag set.
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      orient_change_flag_q <= 1'b0;
    else if (accept && (first_pending_q || differs))
      orient_change_flag_q <= 1'b1;
    else if (status_read)
      orient_change_flag_q <= 1'b0;
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      o_reg_rdata <= 8'h00;
    else if (i_reg_rd)
    begin
      unique case (i_reg_addr)
        odr_pkg::ADDR_STATUS:
          o_reg_rdata <= {orient_change_flag_q, tilt_lockout_q, 3'h0,
                          orient_code_q, back_front_flag_q};
        odr_pkg::ADDR_CONFIG:
          o_reg_rdata <= {debounce_mode_q, orient_detect_enable_q, 6'h00};
        odr_pkg::ADDR_COUNT:
          o_reg_rdata <= debounce_count_value_q;
        default:
          o_reg_rdata <= 8'h00;
      endcase
    end
  end

  assign o_orient_change_flag = orient_change_flag_q;
  // Source follows the flag, so the status read clears both together.
  assign o_orient_irq_source = orient_change_flag_q
                               && i_orient_irq_enable;
endmodule

/* File: sim/odr_orientation_chk_sva.sv */
`timescale 1ns/10ps
module odr_orientation_chk (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  input wire logic i_active,
  input wire logic i_orient_irq_enable,
  input wire logic i_over_range,
  input wire logic o_orient_change_flag,
  input wire logic o_orient_irq_source
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  // Reads in standby are used because no detection can set the flag then.
  wire logic st_rd = i_reg_rd && i_reg_addr == odr_pkg::ADDR_STATUS;
  property p_src;
    o_orient_irq_source == (o_orient_change_flag && i_orient_irq_enable);
  endproperty
  a_src: assert property (p_src) else $error("source not flag and enable");
  property p_clr;
    st_rd && !i_active |=> !o_orient_change_flag;
  endproperty
  a_clr: assert property (p_clr) else $error("flag kept after read");
  property p_src_clr;
    st_rd && !i_active |=> !o_orient_irq_source;
  endproperty
  a_src_clr: assert property (p_src_clr) else $error("source kept");
  property p_idle;
    (!i_active) [*2] |-> !$rose(o_orient_change_flag);
  endproperty
  a_idle: assert property (p_idle) else $error("flag rose in standby");
  property p_frz;
    i_over_range [*2] |-> !$rose(o_orient_change_flag);
  endproperty
  a_frz: assert property (p_frz) else $error("flag rose over range");
  property p_stat;
    st_rd && o_orient_change_flag |=> o_reg_rdata[7] && !o_reg_rdata[5:3];
  endproperty
  a_stat: assert property (p_stat) else $error("status read wrong");
  property p_cfg;
    i_reg_rd && i_reg_addr == odr_pkg::ADDR_CONFIG
      |=> o_reg_rdata[5:0] == 6'h00;
  endproperty
  a_cfg: assert property (p_cfg) else $error("config spare bits set");
  property p_keep;
    o_orient_change_flag && !st_rd |=> o_orient_change_flag;
  endproperty
  a_keep: assert property (p_keep) else $error("flag lost unread");
endmodule
bind odr_orientation_regs odr_orientation_chk chk_u (.*);

/* File: sim/odr_host.sv */
`timescale 1ns/10ps
module odr_host (
  input wire logic i_clock,
  input wire logic [7:0] i_reg_rdata,
  output logic [7:0] o_reg_addr = 8'h00,
  output logic o_reg_wr = 1'b0,
  output logic [7:0] o_reg_wdata = 8'h00,
  output logic o_reg_rd = 1'b0
);
  // One strobe per access; the read data is taken one edge after it.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge i_clock);
    o_reg_addr <= a;
    o_reg_wdata <= d;
    o_reg_wr <= w;
    o_reg_rd <= !w;
    @(posedge i_clock);
    o_reg_wr <= 1'b0;
    o_reg_rd <= 1'b0;
    @(posedge i_clock);
    q = i_reg_rdata;
  endtask
endmodule

/* File: sim/odr_orientation_regs_test.sv */
`timescale 1ns/10ps
module odr_orientation_regs_test;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_active = 1'b0;
  logic i_sleep = 1'b0;
  logic [2:0] i_output_sample_rate = 3'h0;
  logic [1:0] i_oversampling_mode = 2'h0;
  logic i_orient_irq_enable = 1'b1;
  logic i_over_range = 1'b0;
  logic [1:0] i_raw_orient_code = 2'h2;
  logic i_raw_back_front = 1'b1;
  logic i_raw_tilt_lockout = 1'b1;
  wire logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
  wire logic i_reg_wr, i_reg_rd, o_orient_change_flag, o_orient_irq_source;
  logic [7:0] q;
  int n_errors = 0;
  int n_tests = 0;
  always #5 i_clock = !i_clock;
  odr_orientation_regs #(.BASE_CYCLES(4)) dut_u (.*);
  odr_host host_u (.i_clock(i_clock), .i_reg_rdata(o_reg_rdata),
    .o_reg_addr(i_reg_addr), .o_reg_wr(i_reg_wr),
    .o_reg_wdata(i_reg_wdata), .o_reg_rd(i_reg_rd));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host_u.acc(1'b0, a, 8'h00, q);
    chk("rdata", e, q);
  endtask
  task automatic raw(input logic [1:0] c, input logic b, input logic l);
    @(posedge i_clock);
    i_raw_orient_code <= c;
    i_raw_back_front <= b;
    i_raw_tilt_lockout <= l;
  endtask
  task automatic t_reset();
    rd(8'h10, 8'h00);
    rd(8'h11, 8'h80);
    rd(8'h12, 8'h00);
    host_u.acc(1'b1, 8'h10, 8'hFF, q);
    rd(8'h10, 8'h00);
    host_u.acc(1'b1, 8'h12, 8'h02, q);
    rd(8'h12, 8'h02);
    rd(8'h20, 8'h00);
  endtask
  task automatic t_first();
    host_u.acc(1'b1, 8'h11, 8'hC0, q);
    i_active <= 1'b1;
    repeat (20) @(posedge i_clock);
    chk("source", 8'h01, {7'h00, o_orient_irq_source});
    rd(8'h10, 8'hC5);
    chk("source", 8'h00, {7'h00, o_orient_irq_source});
    rd(8'h10, 8'h45);
  endtask
  // Count is 2, so no result may be accepted before a second step tick.
  task automatic t_codes();
    for (int i = 0; i < 4; i++)
    begin
      raw(2'(i + 3), 1'b0, 1'b0);
      repeat (3) @(posedge i_clock);
      chk("early", 8'h00, {7'h00, o_orient_change_flag});
      repeat (20) @(posedge i_clock);
      rd(8'h10, {5'h10, 2'(i + 3), 1'b0});
    end
  endtask
  task automatic t_freeze();
    i_over_range <= 1'b1;
    raw(2'h1, 1'b0, 1'b0);
    repeat (40) @(posedge i_clock);
    chk("frozen", 8'h00, {7'h00, o_orient_change_flag});
    rd(8'h10, 8'h04);
    i_over_range <= 1'b0;
    repeat (20) @(posedge i_clock);
    rd(8'h10, 8'h82);
  endtask
  // Going back to active must flag the first detection even with no change.
  task automatic t_standby();
    i_active <= 1'b0;
    i_orient_irq_enable <= 1'b0;
    repeat (4) @(posedge i_clock);
    i_active <= 1'b1;
    repeat (20) @(posedge i_clock);
    chk("refirst", 8'h01, {7'h00, o_orient_change_flag});
    chk("masked", 8'h00, {7'h00, o_orient_irq_source});
    i_orient_irq_enable <= 1'b1;
    i_active <= 1'b0;
    @(posedge i_clock);
    chk("source", 8'h01, {7'h00, o_orient_irq_source});
    rd(8'h10, 8'h82);
    chk("source", 8'h00, {7'h00, o_orient_irq_source});
    i_active <= 1'b1;
    repeat (20) @(posedge i_clock);
    rd(8'h10, 8'h82);
  endtask
  // A mode change every four cycles never lets two steps pass in a row.
  task automatic t_sleep();
    raw(2'h3, 1'b1, 1'b0);
    repeat (10)
    begin
      i_sleep <= !i_sleep;
      repeat (4) @(posedge i_clock);
    end
    chk("sleep", 8'h00, {7'h00, o_orient_change_flag});
    repeat (20) @(posedge i_clock);
    chk("awake", 8'h01, {7'h00, o_orient_change_flag});
    raw(2'h0, 1'b1, 1'b1);
    repeat (20) @(posedge i_clock);
    rd(8'h10, 8'hC1);
  endtask
  // Count 3: two steps new, one step old, two steps new accepts only when
  // the old step decrements instead of clearing.
  task automatic t_decr();
    host_u.acc(1'b1, 8'h11, 8'h40, q);
    host_u.acc(1'b1, 8'h12, 8'h03, q);
    rd(8'h11, 8'h40);
    raw(2'h2, 1'b1, 1'b1);
    repeat (8) @(posedge i_clock);
    i_raw_orient_code <= 2'h0;
    repeat (4) @(posedge i_clock);
    i_raw_orient_code <= 2'h2;
    repeat (8) @(posedge i_clock);
    @(negedge i_clock);
    chk("decrement", 8'h01, {7'h00, o_orient_change_flag});
    rd(8'h10, 8'hC5);
    host_u.acc(1'b1, 8'h11, 8'hC0, q);
  endtask
  // With count 2 a change is taken after the second step of p cycles.
  task automatic t_step(input logic [2:0] r, input logic [1:0] m,
    input int p, input logic [1:0] c);
    host_u.acc(1'b1, 8'h12, 8'h02, q);
    i_output_sample_rate <= r;
    i_oversampling_mode <= m;
    repeat (2 * p) @(posedge i_clock);
    raw(c, 1'b0, 1'b0);
    repeat (p) @(posedge i_clock);
    @(negedge i_clock);
    chk("one step", 8'h00, {7'h00, o_orient_change_flag});
    repeat (p) @(posedge i_clock);
    @(negedge i_clock);
    chk("steps", 8'h01, {7'h00, o_orient_change_flag});
    rd(8'h10, {5'h10, c, 1'b0});
  endtask
  task automatic t_disable();
    host_u.acc(1'b1, 8'h11, 8'h80, q);
    raw(2'h3, 1'b1, 1'b0);
    repeat (40) @(posedge i_clock);
    rd(8'h10, 8'h02);
  endtask
  task automatic conclude();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    t_reset();
    t_first();
    t_codes();
    t_freeze();
    t_standby();
    t_sleep();
    t_decr();
    t_step(odr_pkg::ODR_200, odr_pkg::OS_HIGH_RESOLUTION, 8,
      2'h1);
    t_step(odr_pkg::ODR_100, odr_pkg::OS_NORMAL, 32, 2'h3);
    t_step(odr_pkg::ODR_12P5, odr_pkg::OS_LOW_NOISE_LOW_POWER, 256,
      2'h0);
    t_step(3'h6, odr_pkg::OS_LOW_POWER, 512, 2'h2);
    t_step(odr_pkg::ODR_800, odr_pkg::OS_NORMAL, 4, 2'h1);
    t_disable();
    conclude();
  end
  // The whole run needs about four thousand cycles, mostly the slow steps.
  initial
  begin
    repeat (20000) @(posedge i_clock);
    n_errors++;
    conclude();
  end
endmodule
